/* rtl/ssq_pkg.sv */
/*
  shared constants, types and helpers of the safe stop sequencer.
  assumes a single 40 MHz system clock and word-indexed registers.
*/
`default_nettype none

package ssq_pkg;

  // ****************************************
  // bus geometry and register indices
  // ****************************************
  localparam int AW = 4;
  localparam int DW = 16;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_MON_TIME = 4'h1;
  localparam logic [3:0] REG_MON_DELAY = 4'h2;
  localparam logic [3:0] REG_STOP_SPEED = 4'h3;
  localparam logic [3:0] REG_DET_DELAY = 4'h4;
  localparam logic [3:0] REG_MON_TC = 4'h5;
  localparam logic [3:0] REG_SPD_OFFSET = 4'h6;
  localparam logic [3:0] REG_ZERO_SPEED = 4'h7;
  localparam logic [3:0] REG_BRK_DELAY = 4'h8;
  localparam logic [3:0] REG_EB_TIME = 4'h9;
  localparam logic [3:0] REG_STATUS = 4'hA;
  localparam logic [3:0] REG_ELAPSED = 4'hB;
  localparam logic [3:0] REG_OBS = 4'hC;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_DECEL_MON = 0;
  localparam int CTRL_FORCED = 1;
  localparam int CTRL_EBRAKE = 2;
  localparam int CTRL_W = 3;
  localparam int ST_B_STO = 0;
  localparam int ST_B_SS1 = 1;
  localparam int ST_B_HOLD = 2;
  localparam int ST_B_METH = 3;
  localparam int ST_B_PEND = 5;
  localparam int ST_B_DRIVE = 6;
  localparam int ST_B_BRAKE = 7;

  // ****************************************
  // reset values, all times in ms
  // ****************************************
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] MON_TIME_RST = 16'h03E8;
  localparam logic [15:0] MON_DELAY_RST = 16'h0000;
  localparam logic [15:0] STOP_SPEED_RST = 16'h0032;
  localparam logic [15:0] DET_DELAY_RST = 16'h000A;
  localparam logic [15:0] MON_TC_RST = 16'h03E8;
  localparam logic [15:0] SPD_OFFSET_RST = 16'h0064;
  localparam logic [15:0] ZERO_SPEED_RST = 16'h0032;
  localparam logic [15:0] BRK_DELAY_RST = 16'h0064;
  localparam logic [15:0] EB_TIME_RST = 16'h07D0;

  // ****************************************
  // timing: one millisecond time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_RUN, ST_TOFF, ST_DECEL, ST_HOLD} ssq_state_e;
  typedef enum logic [1:0] {M_DYN, M_ELEC, M_FDEC} ssq_method_e;

  // ****************************************
  // helpers
  // ****************************************
  // magnitude of a signed speed; -32768 maps to 16'h8000
  function automatic logic [15:0] ssq_abs(input logic [15:0] v);
    ssq_abs = v[15] ? (~v + 16'h0001) : v;
  endfunction

  // saturating millisecond counter step
  function automatic logic [15:0] ssq_inc(input logic [15:0] v);
    ssq_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

endpackage

`default_nettype wire

/* rtl/ssq_obs_ramp.sv */
/*
  observation speed ramp for deceleration monitoring.
  assumes tick is a one-cycle pulse once per millisecond and that
  start is a one-cycle pulse at the moment the stop begins.
*/
`default_nettype none

module ssq_obs_ramp (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  input wire logic tick,
  input wire logic [15:0] start_speed,
  input wire logic [15:0] offset,
  input wire logic [15:0] time_constant,
  output logic [15:0] obs_speed
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] obs;
    logic [31:0] acc;
    logic [15:0] step;
  } ssq_ramp_s;

  ssq_ramp_s q;
  ssq_ramp_s next_q;

  // ****************************************
  // ramp arithmetic
  // ****************************************
  // the ramp loses start_speed over time_constant ms; the division is
  // spread over the clock cycles of each ms, one count per cycle
  always_comb begin
    logic [16:0] sum;
    logic [31:0] acc_t;
    sum = {1'b0, start_speed} + {1'b0, offset};
    acc_t = q.acc;
    next_q = q;
    if (start) begin
      next_q.obs = sum[16] ? 16'hFFFF : sum[15:0];
      next_q.acc = 32'h0000_0000;
      next_q.step = start_speed;
    end else if (run) begin
      if (tick && q.obs != 16'h0000) begin
        acc_t = q.acc + {16'h0000, q.step};
      end
      if (time_constant == 16'h0000) begin
        next_q.obs = 16'h0000; // zero constant: no speed tolerated
      end else if (acc_t >= {16'h0000, time_constant} &&
                   q.obs != 16'h0000) begin
        acc_t = acc_t - {16'h0000, time_constant};
        next_q.obs = q.obs - 16'h0001;
      end
      next_q.acc = acc_t;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign obs_speed = q.obs;

endmodule // ssq_obs_ramp

`default_nettype wire

/* rtl/ssq_sequencer.sv */
/*
  safe stop sequencer: torque off and timed/monitored safe stop one,
  with stop method choice and a small register port.
  assumes command and alarm inputs are synchronous to clk_sys and that
  speeds are signed 16-bit values in one common unit.
*/
`default_nettype none

module ssq_sequencer #(
  parameter int MS_CYCLES = ssq_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic torque_off_command,
  input wire logic safe_stop_one_command,
  input wire logic alarm_torque_off,
  input wire logic alarm_ss1_forced,
  input wire logic alarm_ss1_ebrake,
  input wire logic torque_mode,
  input wire logic torque_continuous,
  input wire logic ebrake_motor,
  input wire logic has_dynamic_brake,
  input wire logic decel_cmd_done,
  input wire logic [15:0] speed_cmd,
  input wire logic [15:0] speed_fb,
  output logic drive_enable,
  output logic dyn_brake_on,
  output logic ebrake_on,
  output logic forced_decel_on,
  output logic sto_state,
  output logic ss1_state,
  output logic [1:0] stop_method
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    ssq_pkg::ssq_state_e state;
    ssq_pkg::ssq_method_e method;
    logic [2:0] ctrl;
    logic [15:0] mon_time;
    logic [15:0] mon_delay;
    logic [15:0] stop_speed;
    logic [15:0] det_delay;
    logic [15:0] mon_tc;
    logic [15:0] spd_offset;
    logic [15:0] zero_speed;
    logic [15:0] brk_delay;
    logic [15:0] eb_time;
    logic [15:0] tick_cnt;
    logic [15:0] elapsed;
    logic [15:0] det;
    logic pend;
    logic [15:0] brk;
    logic fd_off;
    logic dyn_on;
    logic [15:0] rdata;
  } ssq_seq_s;

  ssq_seq_s q;
  ssq_seq_s next_q;

  logic toff_req;
  logic ss1_req;
  logic tick;
  logic ramp_start;
  logic [15:0] obs_speed;
  logic [15:0] cmd_mag;
  logic [15:0] fb_mag;
  logic torq_like;
  logic eb_ok;
  ssq_pkg::ssq_method_e sel_method;
  logic mon_active;
  logic complete;
  logic excess;
  logic time_up;
  logic det_done;
  logic zero_hit;
  logic [15:0] eb_limit;
  logic [15:0] status;

  // ****************************************
  // requests and decoding
  // ****************************************
  // alarms only stop the drive; none is raised here, so an early
  // torque off while moving stays silent
  assign toff_req = !torque_off_command | alarm_torque_off;
  assign ss1_req = !safe_stop_one_command | alarm_ss1_forced |
                   alarm_ss1_ebrake;
  assign tick = q.tick_cnt == 16'(MS_CYCLES - 1);
  assign cmd_mag = ssq_pkg::ssq_abs(speed_cmd);
  assign fb_mag = ssq_pkg::ssq_abs(speed_fb);

  // stop method choice; an electronic-brake alarm alone never picks
  // forced deceleration
  assign torq_like = torque_mode | torque_continuous;
  assign eb_ok = q.ctrl[ssq_pkg::CTRL_EBRAKE] & ebrake_motor;
  always_comb begin
    if (q.ctrl[ssq_pkg::CTRL_FORCED] && !torq_like &&
        (!safe_stop_one_command || alarm_ss1_forced)) begin
      sel_method = ssq_pkg::M_FDEC;
    end else begin
      sel_method = eb_ok ? ssq_pkg::M_ELEC : ssq_pkg::M_DYN;
    end
  end

  // monitoring terms, evaluated only while decelerating
  assign mon_active = q.ctrl[ssq_pkg::CTRL_DECEL_MON] &&
                      q.elapsed >= q.mon_delay;
  assign complete = cmd_mag <= q.stop_speed &&
                    fb_mag <= q.stop_speed;
  assign excess = fb_mag > obs_speed;
  assign time_up = q.elapsed >= q.mon_time;
  assign det_done = q.pend && q.det >= q.det_delay;
  assign zero_hit = decel_cmd_done && fb_mag <= q.zero_speed;
  assign eb_limit = (q.eb_time < q.mon_time) ? q.eb_time : q.mon_time;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_q = q;
    ramp_start = 1'b0;
    next_q.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;

    // register writes; unmapped or read-only indices are ignored
    if (reg_wr) begin
      unique case (reg_addr)
        ssq_pkg::REG_CTRL: next_q.ctrl = reg_wdata[2:0];
        ssq_pkg::REG_MON_TIME: next_q.mon_time = reg_wdata;
        ssq_pkg::REG_MON_DELAY: next_q.mon_delay = reg_wdata;
        ssq_pkg::REG_STOP_SPEED: next_q.stop_speed = reg_wdata;
        ssq_pkg::REG_DET_DELAY: next_q.det_delay = reg_wdata;
        ssq_pkg::REG_MON_TC: next_q.mon_tc = reg_wdata;
        ssq_pkg::REG_SPD_OFFSET: next_q.spd_offset = reg_wdata;
        ssq_pkg::REG_ZERO_SPEED: next_q.zero_speed = reg_wdata;
        ssq_pkg::REG_BRK_DELAY: next_q.brk_delay = reg_wdata;
        ssq_pkg::REG_EB_TIME: next_q.eb_time = reg_wdata;
        default: next_q.ctrl = q.ctrl;
      endcase
    end

    // register reads; unmapped indices return zero
    if (reg_rd) begin
      unique case (reg_addr)
        ssq_pkg::REG_CTRL: next_q.rdata = {13'h0000, q.ctrl};
        ssq_pkg::REG_MON_TIME: next_q.rdata = q.mon_time;
        ssq_pkg::REG_MON_DELAY: next_q.rdata = q.mon_delay;
        ssq_pkg::REG_STOP_SPEED: next_q.rdata = q.stop_speed;
        ssq_pkg::REG_DET_DELAY: next_q.rdata = q.det_delay;
        ssq_pkg::REG_MON_TC: next_q.rdata = q.mon_tc;
        ssq_pkg::REG_SPD_OFFSET: next_q.rdata = q.spd_offset;
        ssq_pkg::REG_ZERO_SPEED: next_q.rdata = q.zero_speed;
        ssq_pkg::REG_BRK_DELAY: next_q.rdata = q.brk_delay;
        ssq_pkg::REG_EB_TIME: next_q.rdata = q.eb_time;
        ssq_pkg::REG_STATUS: next_q.rdata = status;
        ssq_pkg::REG_ELAPSED: next_q.rdata = q.elapsed;
        ssq_pkg::REG_OBS: next_q.rdata = obs_speed;
        default: next_q.rdata = 16'h0000;
      endcase
    end

    // sequence; torque off always outranks deceleration
    unique case (q.state)
      ssq_pkg::ST_RUN: begin
        if (toff_req) begin
          next_q.state = ssq_pkg::ST_TOFF;
        end else if (ss1_req) begin
          next_q.state = ssq_pkg::ST_DECEL;
          next_q.method = sel_method;
          next_q.elapsed = 16'h0000;
          next_q.det = 16'h0000;
          next_q.pend = 1'b0;
          next_q.brk = 16'h0000;
          next_q.fd_off = 1'b0;
          next_q.dyn_on = 1'b0;
          ramp_start = 1'b1;
        end
      end
      ssq_pkg::ST_TOFF: begin
        if (!toff_req) begin
          next_q.state = ssq_pkg::ST_RUN;
        end
      end
      ssq_pkg::ST_DECEL: begin
        if (tick) begin
          next_q.elapsed = ssq_pkg::ssq_inc(q.elapsed);
          if (q.pend) begin
            next_q.det = ssq_pkg::ssq_inc(q.det);
          end
          if (q.fd_off) begin
            next_q.brk = ssq_pkg::ssq_inc(q.brk);
          end
        end
        // a latched detection runs out its delay even if speed recovers
        if (mon_active && (complete || excess)) begin
          next_q.pend = 1'b1;
        end
        if (q.method == ssq_pkg::M_FDEC && zero_hit) begin
          next_q.fd_off = 1'b1;
        end
        if (q.fd_off && q.brk >= q.brk_delay) begin
          next_q.dyn_on = 1'b1;
        end
        if (q.method == ssq_pkg::M_ELEC && q.elapsed >= eb_limit) begin
          next_q.dyn_on = 1'b1;
        end
        if (toff_req) begin
          next_q.state = ssq_pkg::ST_TOFF;
        end else if (!ss1_req) begin
          next_q.state = ssq_pkg::ST_RUN;
        end else if (time_up || det_done) begin
          next_q.state = ssq_pkg::ST_HOLD;
        end
      end
      ssq_pkg::ST_HOLD: begin
        if (toff_req) begin
          next_q.state = ssq_pkg::ST_TOFF;
        end else if (!ss1_req) begin
          next_q.state = ssq_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.state <= ssq_pkg::ST_RUN;
      q.method <= ssq_pkg::M_DYN;
      q.ctrl <= ssq_pkg::CTRL_RST;
      q.mon_time <= ssq_pkg::MON_TIME_RST;
      q.mon_delay <= ssq_pkg::MON_DELAY_RST;
      q.stop_speed <= ssq_pkg::STOP_SPEED_RST;
      q.det_delay <= ssq_pkg::DET_DELAY_RST;
      q.mon_tc <= ssq_pkg::MON_TC_RST;
      q.spd_offset <= ssq_pkg::SPD_OFFSET_RST;
      q.zero_speed <= ssq_pkg::ZERO_SPEED_RST;
      q.brk_delay <= ssq_pkg::BRK_DELAY_RST;
      q.eb_time <= ssq_pkg::EB_TIME_RST;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // observation ramp
  // ****************************************
  ssq_obs_ramp u_ramp (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(ramp_start),
    .run(q.state == ssq_pkg::ST_DECEL),
    .tick(tick),
    .start_speed(fb_mag),
    .offset(q.spd_offset),
    .time_constant(q.mon_tc),
    .obs_speed(obs_speed)
  );

  // ****************************************
  // outputs
  // ****************************************
  // without a fitted brake the brake request simply leaves the motor
  // coasting
  assign sto_state = q.state == ssq_pkg::ST_TOFF ||
                     q.state == ssq_pkg::ST_HOLD;
  assign ss1_state = q.state == ssq_pkg::ST_DECEL ||
                     q.state == ssq_pkg::ST_HOLD;
  assign drive_enable = q.state == ssq_pkg::ST_RUN ||
                        (q.state == ssq_pkg::ST_DECEL &&
                         q.method != ssq_pkg::M_DYN && !q.fd_off &&
                         !q.dyn_on);
  assign dyn_brake_on = has_dynamic_brake &&
                        (sto_state || (q.state == ssq_pkg::ST_DECEL &&
                         (q.method == ssq_pkg::M_DYN || q.dyn_on)));
  assign ebrake_on = q.state == ssq_pkg::ST_DECEL &&
                     q.method == ssq_pkg::M_ELEC && !q.dyn_on;
  assign forced_decel_on = q.state == ssq_pkg::ST_DECEL &&
                           q.method == ssq_pkg::M_FDEC && !q.fd_off;
  assign stop_method = q.method;
  assign reg_rdata = q.rdata;
  assign status = {8'h00, dyn_brake_on, drive_enable, q.pend, q.method,
                   q.state == ssq_pkg::ST_HOLD, ss1_state, sto_state};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_fd_zero;
    q.state == ssq_pkg::ST_DECEL && q.method == ssq_pkg::M_FDEC &&
      zero_hit && ss1_req;
  endsequence

  sequence s_fd_off;
    !drive_enable && !forced_decel_on;
  endsequence

  a_toff_entry: assert property (!torque_off_command |=> sto_state &&
    !ss1_state) else $error("torque off not entered");
  a_toff_energy: assert property (
    q.state == ssq_pkg::ST_TOFF |-> !drive_enable && dyn_brake_on ==
    has_dynamic_brake) else $error("energy or brake wrong in torque off");
  a_toff_release: assert property (q.state == ssq_pkg::ST_TOFF &&
    !toff_req |=> q.state == ssq_pkg::ST_RUN && drive_enable)
    else $error("torque off not released");
  a_alarm_toff: assert property (alarm_torque_off |=> sto_state)
    else $error("alarm did not force torque off");
  a_ss1_start: assert property (q.state == ssq_pkg::ST_RUN &&
    ss1_req && !toff_req |=> q.state == ssq_pkg::ST_DECEL &&
    q.elapsed == 16'h0000) else $error("stop one not started");
  a_mon_timeout: assert property (time_up &&
    q.state == ssq_pkg::ST_DECEL && ss1_req && !toff_req |=>
    q.state == ssq_pkg::ST_HOLD) else $error("monitor time did not escalate");
  a_ss1_release: assert property (ss1_state && !ss1_req &&
    !toff_req |=> q.state == ssq_pkg::ST_RUN)
    else $error("stop one not released");
  a_hold_kept: assert property (q.state == ssq_pkg::ST_HOLD &&
    ss1_req && !toff_req |=> q.state == ssq_pkg::ST_HOLD [*2] or !ss1_req or
    toff_req) else $error("escalated torque off dropped");
  a_early_check: assert property (q.state == ssq_pkg::ST_DECEL &&
    q.elapsed < q.mon_delay && $stable(q.state) && !$past(q.pend) |->
    !q.pend) else $error("speed check before delay");
  a_torque_method: assert property ($rose(ss1_state) &&
    $past(torq_like) |-> q.method != ssq_pkg::M_FDEC)
    else $error("forced decel in torque mode");
  a_fd_shutoff: assert property (s_fd_zero |=> s_fd_off)
    else $error("forced decel did not shut off");
  a_elec_brake: assert property (q.state == ssq_pkg::ST_DECEL &&
    q.method == ssq_pkg::M_ELEC && q.elapsed >= q.eb_time && ss1_req |=>
    dyn_brake_on == has_dynamic_brake && !ebrake_on)
    else $error("electronic brake overran");

endmodule // ssq_sequencer

`default_nettype wire

/* testbench/ssq_ctrl_model.sv */
/*
  model of the external safety controller that drives the stop commands.
  assumes the bench asks for a stop only once the motor may be stopped.
*/
`default_nettype none

module ssq_ctrl_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic want_sto,
  input wire logic want_ss1,
  output logic torque_off_command,
  output logic safe_stop_one_command
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // command outputs
  // ****************************************
  // commands are run permits, so a stop request is a low level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      torque_off_command <= 1'b1;
      safe_stop_one_command <= 1'b1;
    end else begin
      torque_off_command <= !want_sto;
      safe_stop_one_command <= !want_ss1;
    end
  end
endmodule // ssq_ctrl_model

`default_nettype wire

/* testbench/tb.sv */
/*
  self-checking bench of the safe stop sequencer.
  assumes a 1 ms tick shortened to 4 clocks and the controller model.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic want_sto = 1'b0;
  logic want_ss1 = 1'b0;
  logic al_to = 1'b0;
  logic al_sf = 1'b0;
  logic al_se = 1'b0;
  logic tq = 1'b0;
  logic tqc = 1'b0;
  logic ebm = 1'b0;
  logic hdb = 1'b1;
  logic dcd = 1'b0;
  logic [15:0] spc = 16'h0000;
  logic [15:0] spf = 16'h0000;
  logic toc, ssc, drive_en, brake, ebrake, fdecel, sto, ss1;
  logic [1:0] meth;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  ssq_ctrl_model ctl (.clk_sys(clk_sys), .rst(rst), .want_sto(want_sto),
    .want_ss1(want_ss1), .torque_off_command(toc),
    .safe_stop_one_command(ssc));

  ssq_sequencer #(.MS_CYCLES(4)) uut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .torque_off_command(toc),
    .safe_stop_one_command(ssc), .alarm_torque_off(al_to),
    .alarm_ss1_forced(al_sf), .alarm_ss1_ebrake(al_se), .torque_mode(tq),
    .torque_continuous(tqc), .ebrake_motor(ebm), .has_dynamic_brake(hdb),
    .decel_cmd_done(dcd), .speed_cmd(spc), .speed_fb(spf),
    .drive_enable(drive_en), .dyn_brake_on(brake), .ebrake_on(ebrake),
    .forced_decel_on(fdecel), .sto_state(sto), .ss1_state(ss1),
    .stop_method(meth));

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim();
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a hang is cut short and judged as a mismatch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk1(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk16(input string n, input logic [15:0] e,
      input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // let the edge's updates land before looking
  task automatic see(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data appear in the cycle after the strobe and stay until the next read
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk16("reg_rdata", e, reg_rdata);
  endtask

  task automatic wait_sto(input int n);
    for (int i = 0; i < n && sto !== 1'b1; i++) see(1);
    chk1("sto_state", 1'b1, sto);
  endtask

  task automatic wait_brake(input int n);
    for (int i = 0; i < n && brake !== 1'b1; i++) see(1);
    chk1("dyn_brake_on", 1'b1, brake);
  endtask

  // k: 0 stop-one command, 1 forced alarm, 2 electronic brake alarm
  task automatic trig(input int k, input logic v);
    case (k)
      0: want_ss1 <= v;
      1: al_sf <= v;
      default: al_se <= v;
    endcase
  endtask

  task automatic mcase(input logic [2:0] c, input logic t, input logic tc,
      input logic m, input int k, input logic [1:0] e);
    wr(ssq_pkg::REG_CTRL, {13'h0000, c});
    step(1);
    tq <= t;
    tqc <= tc;
    ebm <= m;
    trig(k, 1'b1);
    see(4);
    chk16("stop_method", {14'h0000, e}, {14'h0000, meth});
    chk1("ebrake_on", e == 2'h1, ebrake);
    chk1("forced_decel_on", e == 2'h2, fdecel);
    step(1);
    trig(k, 1'b0);
    see(4);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(20);
    rst <= 1'b0;
    rd(ssq_pkg::REG_MON_TIME, ssq_pkg::MON_TIME_RST);
    rd(ssq_pkg::REG_DET_DELAY, ssq_pkg::DET_DELAY_RST);
    rd(ssq_pkg::REG_EB_TIME, ssq_pkg::EB_TIME_RST);
    rd(4'hD, 16'h0000);
    wr(ssq_pkg::REG_STATUS, 16'hFFFF);
    rd(ssq_pkg::REG_STATUS, 16'h0040);
    wr(ssq_pkg::REG_CTRL, 16'hFFFF);
    rd(ssq_pkg::REG_CTRL, 16'h0007);
    wr(ssq_pkg::REG_CTRL, 16'h0000);
    wr(ssq_pkg::REG_MON_TIME, 16'h0003);
    // plain torque off, then a stop-one request that must wait
    step(1);
    want_sto <= 1'b1;
    see(3);
    chk1("sto_state", 1'b1, sto);
    chk1("drive_enable", 1'b0, drive_en);
    chk1("dyn_brake_on", 1'b1, brake);
    rd(ssq_pkg::REG_STATUS, 16'h0081);
    step(1);
    want_ss1 <= 1'b1;
    see(3);
    chk1("ss1_state", 1'b0, ss1);
    step(1);
    want_sto <= 1'b0;
    want_ss1 <= 1'b0;
    see(3);
    chk1("drive_enable", 1'b1, drive_en);
    // alarm on a unit without a brake: the motor coasts
    step(1);
    al_to <= 1'b1;
    hdb <= 1'b0;
    see(3);
    chk1("sto_state", 1'b1, sto);
    chk1("drive_enable", 1'b0, drive_en);
    chk1("dyn_brake_on", 1'b0, brake);
    step(1);
    al_to <= 1'b0;
    hdb <= 1'b1;
    see(3);
    // timed stop one escalates and holds
    step(1);
    want_ss1 <= 1'b1;
    see(3);
    chk1("ss1_state", 1'b1, ss1);
    chk1("dyn_brake_on", 1'b1, brake);
    chk1("sto_state", 1'b0, sto);
    wait_sto(20);
    see(4);
    chk1("sto_state", 1'b1, sto);
    step(1);
    want_ss1 <= 1'b0;
    see(4);
    chk1("ss1_state", 1'b0, ss1);
    chk1("drive_enable", 1'b1, drive_en);
    // stop method choice
    wr(ssq_pkg::REG_MON_TIME, 16'h0064);
    mcase(3'h6, 1'b0, 1'b0, 1'b1, 0, 2'h2);
    mcase(3'h6, 1'b0, 1'b0, 1'b1, 1, 2'h2);
    mcase(3'h6, 1'b0, 1'b0, 1'b1, 2, 2'h1);
    mcase(3'h6, 1'b0, 1'b0, 1'b0, 2, 2'h0);
    mcase(3'h6, 1'b1, 1'b0, 1'b1, 0, 2'h1);
    mcase(3'h4, 1'b0, 1'b0, 1'b1, 0, 2'h1);
    mcase(3'h6, 1'b0, 1'b1, 1'b0, 1, 2'h0);
    // forced decel: shut off at zero speed, brake after delay
    wr(ssq_pkg::REG_BRK_DELAY, 16'h0002);
    step(1);
    tqc <= 1'b0;
    spf <= 16'h0100;
    want_ss1 <= 1'b1;
    see(4);
    chk1("drive_enable", 1'b1, drive_en);
    step(1);
    dcd <= 1'b1;
    spf <= 16'h0000;
    see(2);
    chk1("drive_enable", 1'b0, drive_en);
    chk1("dyn_brake_on", 1'b0, brake);
    wait_brake(20);
    step(1);
    want_ss1 <= 1'b0;
    dcd <= 1'b0;
    see(4);
    // electronic brake ends at the shorter time
    wr(ssq_pkg::REG_CTRL, 16'h0004);
    wr(ssq_pkg::REG_EB_TIME, 16'h0002);
    step(1);
    ebm <= 1'b1;
    want_ss1 <= 1'b1;
    see(4);
    chk1("dyn_brake_on", 1'b0, brake);
    wait_brake(20);
    chk1("ebrake_on", 1'b0, ebrake);
    step(1);
    want_ss1 <= 1'b0;
    see(4);
    // deceleration monitoring: completion after delays
    wr(ssq_pkg::REG_CTRL, 16'h0001);
    wr(ssq_pkg::REG_MON_DELAY, 16'h0002);
    wr(ssq_pkg::REG_DET_DELAY, 16'h0002);
    step(1);
    want_ss1 <= 1'b1;
    see(5);
    chk1("sto_state", 1'b0, sto);
    // one ms elapsed of a two ms delay: nothing may be pending yet
    rd(ssq_pkg::REG_STATUS, 16'h0082);
    wait_sto(40);
    step(1);
    want_ss1 <= 1'b0;
    see(4);
    // deceleration monitoring: speed over the ramp
    wr(ssq_pkg::REG_MON_DELAY, 16'h0000);
    step(1);
    spc <= 16'h1000;
    spf <= 16'h0100;
    want_ss1 <= 1'b1;
    see(6);
    chk1("sto_state", 1'b0, sto);
    // too few ms have passed for the ramp to have dropped a count
    rd(ssq_pkg::REG_OBS, 16'h0100 + ssq_pkg::SPD_OFFSET_RST);
    step(1);
    spf <= 16'h0400;
    wait_sto(40);
    end_sim();
  end
endmodule // tb

`default_nettype wire
